// >>> core/frame_pkg.sv
package frame_pkg;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_FRAME = 8'h04;
  localparam logic [7:0] REG_LEN = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam logic [7:0] REG_TXB = 8'h10;
  localparam logic [7:0] REG_RXB = 8'h20;
  localparam int CTRL_START = 0;
  localparam int CTRL_ASCII = 1;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_CHK = 2;
  localparam int STAT_EXC = 3;
  localparam int STAT_OVF = 4;
  localparam int STAT_TMO = 5;
  localparam int STAT_ADR = 6;
  localparam int STAT_RXLEN = 8;
  localparam int FRAME_FUNC = 8;
  localparam logic [7:0] CHAR_START = 8'h3A;
  localparam logic [7:0] CHAR_CR = 8'h0D;
  localparam logic [7:0] CHAR_LF = 8'h0A;
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  localparam int EXC_BIT = 7;
  localparam logic [15:0] CRC_SEED = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [4:0] MAX_DATA = 5'h10;
  localparam logic [4:0] RTU_MAX_BYTES = 5'h14;
  localparam logic [4:0] ASC_MAX_BYTES = 5'h13;
  localparam int CLK_KHZ = 250000;
  localparam int IDLE_MS = 10;
  localparam int IDLE_CYCLES = IDLE_MS * CLK_KHZ;
  localparam int RESP_MS = 100;
  localparam int RESP_CYCLES = RESP_MS * CLK_KHZ;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_GAP = 3'b001,
    ST_SEND = 3'b010,
    ST_RECV = 3'b011
  } state_t;

  typedef enum logic [2:0] {
    TP_START = 3'b000,
    TP_BODY = 3'b001,
    TP_CHECK = 3'b010,
    TP_CR = 3'b011,
    TP_LF = 3'b100
  } tpos_t;

  typedef struct packed {
    logic [15:0] crc;
    logic [7:0] lrc;
  } chk_state_t;
endpackage

// >>> core/check_if.sv
`timescale 1ns/1ns
interface check_if;
  logic clr;
  logic feed;
  logic [7:0] data;
  logic [15:0] crc;
  logic [7:0] lrc;
  modport eng(output clr, output feed, output data, input crc, input lrc);
  modport unit(input clr, input feed, input data, output crc, output lrc);
endinterface

// >>> core/frame_check.sv
`timescale 1ns/1ns
module frame_check
  import frame_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  check_if.unit chk
);
  chk_state_t s;
  chk_state_t next_s;

  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0] b);
    logic [15:0] w;
    w = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      w = w[0] ? ((w >> 1) ^ CRC_POLY) : (w >> 1);
    end
    return w;
  endfunction

  always_comb begin
    next_s = s;
    if (chk.clr) begin
      next_s.crc = CRC_SEED; // [R13]
      next_s.lrc = 8'h00;
    end
    if (chk.feed) begin
      next_s.crc = crc_step(next_s.crc, chk.data); // [R14]
      next_s.lrc = next_s.lrc + chk.data; // [R23]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{crc: CRC_SEED, lrc: 8'h00};
    end else begin
      s <= next_s;
    end
  end

  assign chk.crc = s.crc;
  assign chk.lrc = s.lrc;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_seed;
    chk.clr && !chk.feed |=> chk.crc == 16'hFFFF;
  endproperty
  a_seed: assert property (p_seed) else $error("crc not preset"); // [R13]

  property p_modbus_vec;
    chk.clr && chk.feed && chk.data == 8'h01 ##1
    chk.feed && !chk.clr && chk.data == 8'h03 |=> chk.crc == 16'h2140;
  endproperty
  a_modbus_vec: assert property (p_modbus_vec) // [R14]
    else $error("crc step wrong");
endmodule

// >>> core/modbus_master.sv
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ns
// Behaviour
// R1: only the master opens a transaction; replies only to addressed frames
// R2: ascii frames open with colon and close with CR then LF
// R3: ascii sends each byte as two hex characters, high nibble first
// R4: ascii data field holds at most 16 bytes; longer ones are rejected
// R5: rtu frames are bounded by at least 10 ms of line idle
// R6: rtu address and function are single raw bytes; data at most 16
// R7: station zero is broadcast; executed but never answered
// R8: stations 01h to 1Fh address single drives; only own number acts
// R9: function 03h reads, 06h writes one word, 10h writes many
// R10: function 08h is loopback with a test code in place of address
// R11: every register value is exactly two bytes
// R12: received crc is checked; a mismatching frame is discarded
// R13: crc accumulator starts at all ones before the address byte
// R14: byte xored low, eight right shifts, xor A001h when a one drops
// R15: crc goes out low byte first, then high byte
// R16: master checks the crc of every response the same way
// R17: monitor, parameter access and fault reset stay available over link
// R18: primary frequency source value 3 takes reference from the link
// R19: secondary run source value 2 selects link run commands
// R20: station number zero makes the device ignore all traffic
// R21: error replies carry the function code with its top bit set
// R22: frames for other stations are ignored silently
// R23: ascii check byte is the negated 8-bit sum, mismatches discarded
module modbus_master
  import frame_pkg::*;
#(
  parameter int IDLE_CNT = IDLE_CYCLES,
  parameter int RESP_CNT = RESP_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid
);
  typedef struct packed {
    state_t st;
    tpos_t tp;
    logic [4:0] idx;
    logic nib;
    logic ascii;
    logic [7:0] station;
    logic [7:0] func;
    logic [4:0] len;
    logic [15:0][7:0] txb;
    logic [15:0][7:0] rxb;
    logic busy, done, chk_err, exc, ovf, tmo, adr_err;
    logic [4:0] rx_len;
    logic [4:0] rx_cnt;
    logic [7:0] rx_addr, rx_func;
    logic [3:0] rx_hi;
    logic rx_half, rx_frm, rx_cr, rx_bad;
    logic [31:0] idle;
    logic [7:0] tx_data;
    logic tx_valid;
    logic [31:0] prdata;
    logic pready, pslverr;
  } mst_state_t;

  mst_state_t s;
  mst_state_t next_s;
  check_if chk();

  frame_check u_check (.pclk(pclk), .presetn(presetn), .chk(chk));

  function automatic logic [7:0] hex_char(input logic [3:0] v);
    return (v < 4'hA) ? 8'(8'h30 + v) : 8'(8'h37 + v);
  endfunction

  function automatic logic [4:0] hex_val(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) return {1'b1, 4'(c - 8'h30)};
    if (c >= 8'h41 && c <= 8'h46) return {1'b1, 4'(c - 8'h37)};
    return 5'h00;
  endfunction

  function automatic logic reg_ok(input logic [7:0] a);
    return a[1:0] == 2'b00 && a < 8'h30;
  endfunction

  function automatic logic [7:0] body_byte(input mst_state_t x);
    if (x.idx == 5'h00) return x.station;
    if (x.idx == 5'h01) return x.func;
    return x.txb[4'(x.idx - 5'h02)];
  endfunction

  function automatic logic [7:0] emit(input mst_state_t x,
                                      input logic [15:0] crc,
                                      input logic [7:0] lrc);
    logic [7:0] b;
    logic [7:0] l;
    b = body_byte(x);
    l = 8'(8'h00 - lrc);
    unique case (x.tp)
      TP_START: return CHAR_START; // [R2]
      TP_BODY: begin
        if (!x.ascii) return b; // [R6]
        return hex_char(x.nib ? b[3:0] : b[7:4]); // [R3]
      end
      TP_CHECK: begin
        if (x.ascii) return hex_char(x.nib ? l[3:0] : l[7:4]); // [R23]
        return x.nib ? crc[15:8] : crc[7:0]; // [R15]
      end
      TP_CR: return CHAR_CR;
      TP_LF: return CHAR_LF;
      default: return 8'h00;
    endcase
  endfunction

  function automatic logic [31:0] rd(input mst_state_t x,
                                     input logic [7:0] a);
    logic [3:0] w;
    w = 4'(a[3:2]);
    unique case (a[7:4])
      4'h0: begin
        unique case (a[3:2])
          2'h0: return {30'h0, x.ascii, 1'b0};
          2'h1: return {16'h0, x.func, x.station};
          2'h2: return {27'h0, x.len};
          default: return {19'h0, x.rx_len, 1'b0, x.adr_err, x.tmo,
                           x.ovf, x.exc, x.chk_err, x.done, x.busy};
        endcase
      end
      4'h1: return {x.txb[{w[1:0], 2'h3}], x.txb[{w[1:0], 2'h2}],
                    x.txb[{w[1:0], 2'h1}], x.txb[{w[1:0], 2'h0}]};
      4'h2: return {x.rxb[{w[1:0], 2'h3}], x.rxb[{w[1:0], 2'h2}],
                    x.rxb[{w[1:0], 2'h1}], x.rxb[{w[1:0], 2'h0}]};
      default: return 32'h0;
    endcase
  endfunction

  logic fin;
  logic [4:0] hv;
  logic [7:0] rb;

  always_comb begin
    next_s = s;
    chk.clr = 1'b0;
    chk.feed = 1'b0;
    chk.data = 8'h00;
    fin = 1'b0;
    hv = hex_val(rx_data);
    rb = 8'h00;
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    if (psel && penable && !s.pready) begin
      next_s.pready = 1'b1;
      next_s.pslverr = !reg_ok(paddr);
      next_s.prdata = reg_ok(paddr) ? rd(s, paddr) : 32'h0;
    end
    if (psel && penable && pwrite && s.pready && reg_ok(paddr)) begin
      if (paddr == REG_STAT) begin
        if (pwdata[STAT_DONE]) next_s.done = 1'b0;
      end else if (!s.busy) begin
        if (paddr == REG_CTRL) begin
          next_s.ascii = pwdata[CTRL_ASCII];
          if (pwdata[CTRL_START]) begin
            next_s.busy = 1'b1; // [R1]
            next_s.st = ST_GAP;
            next_s.done = 1'b0;
            {next_s.chk_err, next_s.exc, next_s.ovf} = 3'b000;
            {next_s.tmo, next_s.adr_err} = 2'b00;
            next_s.rx_len = 5'h00;
          end
        end else if (paddr == REG_FRAME) begin
          next_s.station = pwdata[7:0];
          next_s.func = pwdata[FRAME_FUNC +: 8];
        end else if (paddr == REG_LEN) begin
          if (pwdata[4:0] <= MAX_DATA && pwdata[31:5] == 27'h0) begin
            next_s.len = pwdata[4:0]; // [R4]
          end
        end else if (paddr[5:4] == 2'b01) begin
          for (int k = 0; k < 4; k++) begin
            next_s.txb[{paddr[3:2], 2'(k)}] = pwdata[8*k +: 8]; // [R11]
          end
        end
      end
    end
    if (rx_valid || (s.tx_valid && tx_ready)) begin
      next_s.idle = 32'h0;
    end else if (s.idle != 32'hFFFF_FFFF) begin
      next_s.idle = s.idle + 32'h1;
    end
    unique case (s.st)
      ST_IDLE: ;
      ST_GAP: begin
        chk.clr = 1'b1;
        if (s.ascii || s.idle >= 32'(IDLE_CNT)) begin // [R5]
          next_s.st = ST_SEND;
          next_s.tp = s.ascii ? TP_START : TP_BODY;
          next_s.idx = 5'h00;
          next_s.nib = 1'b0;
          next_s.tx_valid = 1'b1;
          chk.feed = 1'b1; // [R13]
          chk.data = s.station;
          next_s.tx_data = emit(next_s, chk.crc, chk.lrc);
        end
      end
      ST_SEND: begin
        if (s.tx_valid && tx_ready) begin
          unique case (s.tp)
            TP_START: next_s.tp = TP_BODY;
            TP_BODY: begin
              if (s.ascii && !s.nib) begin
                next_s.nib = 1'b1;
              end else begin
                next_s.nib = 1'b0;
                if (s.idx == 5'(s.len + 5'h01)) begin
                  next_s.tp = TP_CHECK;
                end else begin
                  next_s.idx = s.idx + 5'h01;
                  chk.feed = 1'b1;
                  chk.data = body_byte(next_s);
                end
              end
            end
            TP_CHECK: begin
              if (!s.nib) next_s.nib = 1'b1;
              else if (s.ascii) next_s.tp = TP_CR;
              else fin = 1'b1;
            end
            TP_CR: next_s.tp = TP_LF;
            default: fin = 1'b1;
          endcase
          if (fin) begin
            next_s.tx_valid = 1'b0;
            chk.clr = 1'b1;
            {next_s.rx_cnt, next_s.rx_half} = 6'h00;
            {next_s.rx_frm, next_s.rx_cr, next_s.rx_bad} = 3'b000;
            if (s.station == BCAST_ADDR) begin // [R7]
              next_s.st = ST_IDLE;
              next_s.busy = 1'b0;
              next_s.done = 1'b1;
            end else begin
              next_s.st = ST_RECV;
            end
          end else begin
            next_s.tx_data = emit(next_s, chk.crc, chk.lrc);
          end
        end
      end
      ST_RECV: begin
        if (rx_valid && s.ascii) begin
          if (rx_data == CHAR_START) begin // [R2]
            chk.clr = 1'b1;
            {next_s.rx_cnt, next_s.rx_half} = 6'h00;
            {next_s.rx_frm, next_s.rx_cr, next_s.rx_bad} = 3'b100;
          end else if (s.rx_frm) begin
            if (rx_data == CHAR_CR) next_s.rx_cr = 1'b1;
            else if (rx_data == CHAR_LF && s.rx_cr) fin = 1'b1;
            else if (!hv[4] || s.rx_cr) next_s.rx_bad = 1'b1;
            else if (!s.rx_half) begin
              next_s.rx_hi = hv[3:0]; // [R3]
              next_s.rx_half = 1'b1;
            end else begin
              next_s.rx_half = 1'b0;
              rb = {s.rx_hi, hv[3:0]};
              chk.feed = 1'b1;
            end
          end
        end else if (rx_valid) begin
          rb = rx_data; // [R6]
          chk.feed = 1'b1;
        end else if (!s.ascii && s.rx_cnt != 5'h00 &&
                     s.idle >= 32'(IDLE_CNT)) begin
          fin = 1'b1; // [R5]
        end
        if (chk.feed) begin
          chk.data = rb;
          if (s.rx_cnt == 5'h00) next_s.rx_addr = rb;
          else if (s.rx_cnt == 5'h01) next_s.rx_func = rb;
          else if (s.rx_cnt < 5'h12) next_s.rxb[4'(s.rx_cnt - 5'h02)] = rb;
          if (s.rx_cnt != 5'h1F) next_s.rx_cnt = s.rx_cnt + 5'h01;
        end
        if (fin) begin
          next_s.st = ST_IDLE;
          next_s.busy = 1'b0;
          next_s.done = 1'b1;
          next_s.exc = s.rx_func[EXC_BIT]; // [R21]
          next_s.adr_err = s.rx_addr != s.station; // [R22]
          if (s.ascii) begin
            next_s.chk_err = chk.lrc != 8'h00 || s.rx_bad || // [R23]
                             s.rx_half || s.rx_cnt < 5'h03;
            next_s.ovf = s.rx_cnt > ASC_MAX_BYTES; // [R4]
            next_s.rx_len = next_s.ovf ? MAX_DATA : 5'(s.rx_cnt - 5'h03);
          end else begin
            next_s.chk_err = chk.crc != 16'h0 || s.rx_cnt < 5'h04; // [R16]
            next_s.ovf = s.rx_cnt > RTU_MAX_BYTES; // [R6]
            next_s.rx_len = next_s.ovf ? MAX_DATA : 5'(s.rx_cnt - 5'h04);
          end
          if (next_s.chk_err) next_s.rx_len = 5'h00; // [R12]
        end else if (s.rx_cnt == 5'h00 && !s.rx_frm &&
                     s.idle >= 32'(RESP_CNT)) begin
          next_s.st = ST_IDLE;
          next_s.busy = 1'b0;
          next_s.done = 1'b1;
          next_s.tmo = 1'b1;
        end
      end
      default: next_s.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign tx_data = s.tx_data;
  assign tx_valid = s.tx_valid;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_quiet;
    !s.busy |-> !tx_valid;
  endproperty
  a_quiet: assert property (p_quiet) else $error("tx while idle"); // [R1]

  property p_colon;
    $rose(tx_valid) && s.ascii |-> tx_data == 8'h3A;
  endproperty
  a_colon: assert property (p_colon) else $error("no colon"); // [R2]

  property p_gap;
    $rose(tx_valid) && !s.ascii |-> $past(s.idle) >= IDLE_CNT;
  endproperty
  a_gap: assert property (p_gap) else $error("gap too short"); // [R5]

  property p_bcast;
    s.st == ST_RECV |-> s.station != 8'h00;
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast waits"); // [R7]

  property p_crc_lo;
    tx_valid && !s.ascii && s.tp == TP_CHECK && !s.nib |->
      (tx_data == chk.crc[7:0]) and
      (tx_ready |=> tx_data == $past(chk.crc[15:8]));
  endproperty
  a_crc_lo: assert property (p_crc_lo) else $error("crc order"); // [R15]

  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  a_hold: assert property (p_hold) else $error("tx dropped"); // [R3]

  property p_chk;
    $rose(s.done) && !s.ascii && !s.tmo && !$past(s.tx_valid) |->
      s.chk_err == ($past(chk.crc) != 16'h0 || $past(s.rx_cnt) < 5'h04);
  endproperty
  a_chk: assert property (p_chk) else $error("crc verdict"); // [R12]

  property p_ovf;
    $rose(s.done) && s.ovf && !s.chk_err |-> s.rx_len == 5'h10;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow length"); // [R4]
endmodule

// >>> verification/mb_tb_pkg.sv
package mb_tb_pkg;
  typedef logic [7:0] byte_q_t[$];
  function automatic logic [15:0] crc16(byte_q_t q);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction
  function automatic logic [7:0] sum8(byte_q_t q);
    logic [7:0] s;
    s = 8'h00;
    foreach (q[i]) s = s + q[i];
    return s;
  endfunction
  function automatic logic [7:0] hx(logic [3:0] n);
    return n < 4'hA ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction
  function automatic logic [3:0] nib(logic [7:0] ch);
    return ch > 8'h40 ? 4'(ch - 8'h37) : 4'(ch - 8'h30);
  endfunction
  // whole frame as it appears on the wire
  function automatic byte_q_t mkf(logic asc, byte_q_t b);
    byte_q_t q;
    logic [15:0] c;
    c = crc16(b);
    q = {b, c[7:0], c[15:8]};
    if (!asc) return q;
    q = {b, 8'h00 - sum8(b)};
    b = {8'h3A};
    foreach (q[i]) b = {b, hx(q[i][7:4]), hx(q[i][3:0])};
    b = {b, 8'h0D, 8'h0A};
    return b;
  endfunction
endpackage

// >>> verification/modbus_slave_model.sv
`timescale 1ns/1ns
module modbus_slave_model
  import mb_tb_pkg::*;
#(
  parameter int IDLE = 50
) (
  input wire logic pclk,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid
);
  // knobs changed by the bench only between frames
  logic [7:0] station = 8'h01;
  logic ascii = 1'b0;
  logic slow = 1'b0;
  logic bad_crc = 1'b0;
  logic [15:0] regs [16];
  // link-written words that steer the drive, gated by its source selectors
  logic [15:0] freq_ref = 16'h0000;
  logic [15:0] run_cmd = 16'h0000;
  logic select_switch = 1'b0;
  byte_q_t rq, b, r, f;
  int idle = 0;

  // replies only to a command addressed here
  task automatic serve();
    int a;
    r = {};
    if (b.size() < 4 || b.size() > 18) return;
    if (station == 8'h00) return;
    if (b[0] != 8'h00 && b[0] != station) return;
    a = {b[2], b[3]};
    case (b[1])
      8'h03: begin
        r = {b[0], b[1], 8'(2 * b[5])};
        for (int i = 0; i < b[5]; i++) begin
          r.push_back(regs[(a + i) % 16][15:8]);
          r.push_back(regs[(a + i) % 16][7:0]);
        end
      end
      8'h06: begin
        regs[a % 16] = {b[4], b[5]};
        r = b;
      end
      8'h08: r = b;
      8'h10: begin
        for (int i = 0; i < b[5]; i++)
          regs[(a + i) % 16] = {b[7 + 2 * i], b[8 + 2 * i]};
        r = b[0:5];
      end
      default: r = {b[0], b[1] | 8'h80, 8'h01};
    endcase
    // word 0 primary frequency source, 1 secondary run source,
    // 3 stands for all multifunction input settings, 4 and 5 link words
    if (regs[0] == 16'h0003) freq_ref = regs[4];
    if (regs[1] == 16'h0002 && regs[3] == 16'h0004 && !select_switch)
      run_cmd = regs[5];
    if (b[0] == 8'h00) r = {};
  endtask

  task automatic send();
    if (slow) repeat (40) @(posedge pclk);
    foreach (f[i]) begin
      rx_valid <= 1'b1;
      rx_data <= f[i];
      @(posedge pclk);
    end
    rx_valid <= 1'b0;
    // a released line must not look like a held byte
    rx_data <= ~f[$];
  endtask

  initial begin
    foreach (regs[i]) regs[i] = 16'h0000;
    tx_ready = 1'b1;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    forever begin
      @(posedge pclk);
      tx_ready <= slow ? ~tx_ready : 1'b1;
      idle = (tx_valid && tx_ready) ? 0 : idle + 1;
      if (tx_valid && tx_ready) rq.push_back(tx_data);
      if (rq.size() > 0 &&
          (ascii ? rq[$] == 8'h0A : idle >= IDLE)) begin
        b = rq;
        if (ascii) b = {};
        for (int i = 1; ascii && i < rq.size() - 2; i += 2)
          b.push_back({nib(rq[i]), nib(rq[i + 1])});
        rq = {};
        if (ascii ? sum8(b) == 8'h00 :
            crc16(b) == 16'h0000) begin
          b = b[0:$ - (ascii ? 1 : 2)];
          serve();
          if (r.size() > 0) begin
            f = mkf(ascii, r);
            if (bad_crc) f[$] = ~f[$];
            send();
          end
        end
        idle = 0;
      end
    end
  end
endmodule

// >>> verification/modbus_slave_frame_engine_tb.sv
`timescale 1ns/1ns
module modbus_slave_frame_engine_tb
  import frame_pkg::*, mb_tb_pkg::*;
();
  localparam int IDLE = 50;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, tx_valid, tx_ready, rx_valid;
  logic [7:0] tx_data, rx_data;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int gap = 0;
  logic asc = 1'b0;
  byte_q_t txq;

  modbus_master #(.IDLE_CNT(IDLE), .RESP_CNT(200)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid)
  );
  modbus_slave_model #(.IDLE(IDLE)) slave (
    .pclk(pclk), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid)
  );

  always #2 pclk = ~pclk;

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(logic [31:0] got, logic [31:0] exp, string m);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask

  task automatic chkq(byte_q_t got, byte_q_t exp);
    chk(32'(got.size()), 32'(exp.size()), "link length");
    foreach (exp[i])
      if (i < got.size()) chk(32'(got[i]), 32'(exp[i]), "link byte");
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    gap <= (rx_valid || (tx_valid && tx_ready)) ? 0 : gap + 1;
    if (tx_valid && tx_ready) begin
      if (txq.size() == 0 && !asc)
        chk(32'(gap >= IDLE), 32'h1, "gap");
      txq.push_back(tx_data);
    end
    if (cyc == 40000) begin
      n_errors++;
      conclude();
    end
  end

  task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask

  task automatic go(logic a, logic [7:0] st, logic [7:0] fn, byte_q_t d,
                    logic [3:0] fl, logic cw, logic [31:0] w0,
                    output logic [31:0] s);
    logic [31:0] w;
    byte_q_t q;
    asc = a;
    txq = {};
    wr(REG_FRAME, {16'h0000, fn, st});
    wr(REG_LEN, 32'(d.size()));
    for (int k = 0; k < 4; k++) begin
      w = 32'h0;
      for (int j = 0; j < 4; j++)
        if (4 * k + j < d.size()) w[8 * j +: 8] = d[4 * k + j];
      wr(REG_TXB + 8'(4 * k), w);
    end
    wr(REG_CTRL, {30'h0, a, 1'b1});
    s = 32'h0;
    while (s[STAT_DONE] !== 1'b1) rd(REG_STAT, s);
    wr(REG_STAT, 32'h2);
    q = {st, fn, d};
    chkq(txq, mkf(a, q));
    chk(32'(s[5:2]), 32'(fl), "flags");
    if (cw) rd(REG_RXB, w);
    if (cw) chk(w, w0, "rx word");
  endtask

  initial begin
    logic [31:0] r, s;
    logic e;
    logic [15:0] c;
    byte_q_t q;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int k = 0; k < 4; k++) begin
      rd(8'(4 * k), r);
      chk(r, 32'h0, "reset value");
    end
    apb(1'b0, 8'h30, 32'h0, r, e);
    chk(r, 32'h0, "unmapped data");
    chk(32'(e), 32'h1, "unmapped error");
    wr(REG_LEN, 32'h5);
    wr(REG_LEN, 32'h11);
    rd(REG_LEN, r);
    chk(r, 32'h5, "len limit");
    q = {8'h01, 8'h03, 8'h24, 8'h22, 8'h00, 8'h02};
    chk(32'(crc16(q)), 32'hF16E, "crc");
    q = {8'h00, 8'h02, 8'h12, 8'h34};
    go(1'b0, 8'h01, 8'h06, q, 4'h0, 1'b1, 32'h34120200, s);
    q = {8'h00, 8'h00, 8'h00, 8'h03};
    go(1'b0, 8'h01, 8'h06, q, 4'h0, 1'b1, 32'h03000000, s);
    q = {8'h00, 8'h04, 8'h00, 8'h02, 8'h04, 8'hAB, 8'hCD, 8'h00, 8'h5A};
    go(1'b0, 8'h01, 8'h10, q, 4'h0, 1'b1, 32'h02000400, s);
    chk(32'(slave.freq_ref), 32'h0000ABCD, "freq ref");
    chk(32'(slave.run_cmd), 32'h0, "run cmd");
    q = {8'h00, 8'h04, 8'h00, 8'h02};
    go(1'b0, 8'h01, 8'h03, q, 4'h0, 1'b1, 32'h00CDAB04, s);
    q = {8'h00, 8'h00, 8'hA5, 8'h5A};
    go(1'b0, 8'h01, 8'h08, q, 4'h0, 1'b1, 32'h5AA50000, s);
    q = {8'h00, 8'h03, 8'h07, 8'h77};
    go(1'b0, 8'h00, 8'h06, q, 4'h0, 1'b0, 32'h0, s);
    q = {8'h01, 8'h03, 8'h02, 8'h07, 8'h77};
    c = crc16(q);
    q = {8'h00, 8'h03, 8'h00, 8'h01};
    go(1'b0, 8'h01, 8'h03, q, 4'h0, 1'b1, {c[7:0], 24'h770702}, s);
    go(1'b0, 8'h05, 8'h03, q, 4'h8, 1'b0, 32'h0, s);
    slave.bad_crc = 1'b1;
    go(1'b0, 8'h01, 8'h03, q, 4'h1, 1'b0, 32'h0, s);
    chk(32'(s[12:8]), 32'h0, "rx len");
    slave.bad_crc = 1'b0;
    go(1'b0, 8'h01, 8'h05, q, 4'h2, 1'b0, 32'h0, s);
    q = {8'h00, 8'h00, 8'h00, 8'h08};
    go(1'b0, 8'h01, 8'h03, q, 4'h4, 1'b0, 32'h0, s);
    chk(32'(s[12:8]), 32'h10, "rx len");
    slave.slow = 1'b1;
    slave.ascii = 1'b1;
    q = {8'h00, 8'h02, 8'h12, 8'h34};
    go(1'b1, 8'h01, 8'h06, q, 4'h0, 1'b1, 32'h34120200, s);
    slave.station = 8'h00;
    go(1'b1, 8'h01, 8'h06, q, 4'h8, 1'b0, 32'h0, s);
    conclude();
  end
endmodule
